// ---- src/ret_rot_pkg.sv ----
// Package for the return and rotate execute unit: opcodes, field layout,
// cycle counts and the carrier structs shared by the unit's ports.
// Assumes a 14-bit instruction word and an 8-bit data path.
package ret_rot_pkg;

  localparam int unsigned INSN_W   = 14;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned FADDR_W  = 7;
  localparam int unsigned PC_W     = 13;

  // Field positions inside the instruction word.
  localparam int unsigned LIT_LSB  = 0;
  localparam int unsigned FADDR_LSB = 0;
  localparam int unsigned DEST_BIT = 7;

  // Opcode patterns and masks.
  localparam logic [13:0] RETLIT_MASK = 14'h3c00;
  localparam logic [13:0] RETLIT_PAT  = 14'h3400;
  localparam logic [13:0] RETURN_WORD = 14'h0008;
  localparam logic [13:0] ROT_MASK    = 14'h3f00;
  localparam logic [13:0] RRC_PAT     = 14'h0c00;
  localparam logic [13:0] RLC_PAT     = 14'h0d00;

  // Instruction cycles taken by a return; rotates take one.
  localparam logic [1:0] RET_CYCLES = 2'h2;

  // Reset values.
  localparam logic [7:0] W_RST     = 8'h00;
  localparam logic       CARRY_RST = 1'b0;

  typedef struct packed {
    logic                valid;
    logic [INSN_W-1:0]   word;
  } insn_t;

  typedef struct packed {
    logic                wr;
    logic [FADDR_W-1:0]  addr;
    logic [DATA_W-1:0]   data;
  } file_wr_t;

  typedef struct packed {
    logic                pop;
    logic                pc_load;
    logic [PC_W-1:0]     pc;
    logic                flush;
  } flow_t;

endpackage

// ---- src/return_rotate_exec_unit.sv ----
// Execute unit for the literal return, plain return and the two
// rotate-through-carry instructions of an 8-bit core.
// Assumes the fetch path holds the instruction while busy_o is high and
// that file register reads are combinational on file_raddr_o.
`timescale 1ns/1ps
module return_rotate_exec_unit (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_b_i,
  // Instruction from fetch
  input  wire ret_rot_pkg::insn_t            insn_i,
  // Hardware stack
  input  wire logic [ret_rot_pkg::PC_W-1:0]  top_of_stack_i,
  // File register read data
  input  wire logic [ret_rot_pkg::DATA_W-1:0] file_rdata_i,
  // File register access
  output logic [ret_rot_pkg::FADDR_W-1:0]    file_raddr_o,
  output ret_rot_pkg::file_wr_t              file_wr_o,
  // Program flow
  output ret_rot_pkg::flow_t                 flow_o,
  output logic                               busy_o,
  // Core state
  output logic [ret_rot_pkg::DATA_W-1:0]     w_o,
  output logic                               carry_o
);

  typedef enum logic [0:0] {
    ST_EXEC  = 1'b0,
    ST_FLUSH = 1'b1
  } state_t;

  // Sequencer state.
  state_t                                state_ff;
  state_t                                nxt_state;
  // Working register and carry flag of the core.
  logic [ret_rot_pkg::DATA_W-1:0]        w_ff;
  logic [ret_rot_pkg::DATA_W-1:0]        nxt_w;
  logic                                  carry_ff;
  logic                                  nxt_carry;
  // Registered side effects toward the file registers and program counter.
  ret_rot_pkg::file_wr_t                 fwr_ff;
  ret_rot_pkg::file_wr_t                 nxt_fwr;
  ret_rot_pkg::flow_t                    flow_ff;
  ret_rot_pkg::flow_t                    nxt_flow;

  logic                                  taken;
  logic                                  is_retlit;
  logic                                  is_return;
  logic                                  is_ret;
  logic                                  is_rrc;
  logic                                  is_rlc;
  logic                                  is_rot;
  logic                                  to_file;
  logic [ret_rot_pkg::DATA_W-1:0]        rrc_res;
  logic [ret_rot_pkg::DATA_W-1:0]        rlc_res;
  logic [ret_rot_pkg::DATA_W-1:0]        rot_res;
  logic                                  rot_carry;

  // A word offered during the flush cycle is the wrong-path prefetch, so it
  // is never taken, whatever its opcode.
  assign taken     = insn_i.valid && (state_ff == ST_EXEC);

  assign is_retlit = taken &&
                     ((insn_i.word & ret_rot_pkg::RETLIT_MASK) == ret_rot_pkg::RETLIT_PAT);
  assign is_return = taken && (insn_i.word == ret_rot_pkg::RETURN_WORD);
  assign is_ret    = is_retlit || is_return;
  assign is_rrc    = taken &&
                     ((insn_i.word & ret_rot_pkg::ROT_MASK) == ret_rot_pkg::RRC_PAT);
  assign is_rlc    = taken &&
                     ((insn_i.word & ret_rot_pkg::ROT_MASK) == ret_rot_pkg::RLC_PAT);
  assign is_rot    = is_rrc || is_rlc;
  assign to_file   = insn_i.word[ret_rot_pkg::DEST_BIT];

  assign file_raddr_o = insn_i.word[ret_rot_pkg::FADDR_LSB +: ret_rot_pkg::FADDR_W];

  // Both rotate results are formed bit by bit from the read data and the
  // stored carry; the opcode only picks one of them afterwards.
  for (genvar b = 0; b < ret_rot_pkg::DATA_W; b++) begin : g_rot_bit
    if (b == ret_rot_pkg::DATA_W - 1) begin : g_rrc_top
      assign rrc_res[b] = carry_ff;
    end else begin : g_rrc_mid
      assign rrc_res[b] = file_rdata_i[b+1];
    end
    if (b == 0) begin : g_rlc_low
      assign rlc_res[b] = carry_ff;
    end else begin : g_rlc_mid
      assign rlc_res[b] = file_rdata_i[b-1];
    end
  end

  assign rot_res   = is_rlc ? rlc_res : rrc_res;
  assign rot_carry = is_rlc ? file_rdata_i[ret_rot_pkg::DATA_W-1] : file_rdata_i[0];

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_EXEC: begin
        if (is_ret) begin
          nxt_state = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        nxt_state = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= ST_EXEC;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_comb begin
    nxt_w = w_ff;
    if (is_retlit) begin
      nxt_w = insn_i.word[ret_rot_pkg::LIT_LSB +: ret_rot_pkg::DATA_W];
    end else if (is_rot && !to_file) begin
      nxt_w = rot_res;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      w_ff <= ret_rot_pkg::W_RST;
    end else begin
      w_ff <= nxt_w;
    end
  end

  // Zero and digit-carry live outside this block; leaving them alone when a
  // rotate retires is the core's side of the bargain.
  always_comb begin
    nxt_carry = carry_ff;
    if (is_rot) begin
      nxt_carry = rot_carry;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      carry_ff <= ret_rot_pkg::CARRY_RST;
    end else begin
      carry_ff <= nxt_carry;
    end
  end

  // The write-back lands one cycle after the read, so a rotate on the same
  // address right behind it reads the old value unless the core forwards
  // the pending write.
  always_comb begin
    nxt_fwr = '0;
    if (is_rot && to_file) begin
      nxt_fwr.wr   = 1'b1;
      nxt_fwr.addr = file_raddr_o;
      nxt_fwr.data = rot_res;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fwr_ff <= '0;
    end else begin
      fwr_ff <= nxt_fwr;
    end
  end

  // Pop and load are one-cycle pulses; the flush pulse follows them a cycle
  // later, which gives the fetch path time to finish the jump first.
  always_comb begin
    nxt_flow = '0;
    if (is_ret) begin
      nxt_flow.pop     = 1'b1;
      nxt_flow.pc_load = 1'b1;
      nxt_flow.pc      = top_of_stack_i;
    end
    if (state_ff == ST_FLUSH) begin
      nxt_flow.flush = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flow_ff <= '0;
    end else begin
      flow_ff <= nxt_flow;
    end
  end

  // Busy covers the flush cycle so fetch holds off the wrong-path word.
  assign busy_o    = (state_ff == ST_FLUSH);
  assign file_wr_o = fwr_ff;
  assign flow_o    = flow_ff;
  assign w_o       = w_ff;
  assign carry_o   = carry_ff;

endmodule // return_rotate_exec_unit

// ---- verif/ret_rot_monitor.sv ----
// Checker for the return and rotate execute unit, bound to its ports.
// Assumes the unit's package is compiled first.
`timescale 1ns/1ps
module ret_rot_monitor (
  input wire logic                 clk_i,
  input wire logic                 rst_b_i,
  input wire ret_rot_pkg::insn_t   insn_i,
  input wire logic [12:0]          top_of_stack_i,
  input wire logic [7:0]           file_rdata_i,
  input wire logic [6:0]           file_raddr_o,
  input wire ret_rot_pkg::file_wr_t file_wr_o,
  input wire ret_rot_pkg::flow_t   flow_o,
  input wire logic                 busy_o,
  input wire logic [7:0]           w_o,
  input wire logic                 carry_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire       tk  = insn_i.valid && !busy_o;
  wire       rl  = tk && (insn_i.word & 14'h3c00) == 14'h3400;
  wire       rt  = tk && insn_i.word == 14'h0008;
  wire       rr  = tk && insn_i.word[13:8] == 6'h0c;
  wire       rf  = tk && insn_i.word[13:8] == 6'h0d;
  wire [7:0] res = file_wr_o.wr ? file_wr_o.data : w_o;
  sequence s_flush;
    busy_o ##1 (flow_o.flush && !busy_o);
  endsequence
  a_lit_to_w: assert property (rl |=> w_o == $past(insn_i.word[7:0]))
    else $error("literal not in w");
  a_ret_pop_pc: assert property ((rl || rt) |=> flow_o.pop && flow_o.pc_load
    && flow_o.pc == $past(top_of_stack_i)) else $error("return did not pop");
  a_ret_two_cyc: assert property ((rl || rt) |=> s_flush)
    else $error("return flush cycle wrong");
  a_ret_keep_flags: assert property (rt |=> $stable(w_o) && $stable(carry_o))
    else $error("plain return changed state");
  a_rot_right: assert property (rr |=> carry_o == $past(file_rdata_i[0])
    && res == {$past(carry_o), $past(file_rdata_i[7:1])}) else $error("rotate right wrong");
  a_rot_left: assert property (rf |=> carry_o == $past(file_rdata_i[7])
    && res == {$past(file_rdata_i[6:0]), $past(carry_o)}) else $error("rotate left wrong");
  a_rot_dest: assert property ((rr || rf) |=> file_wr_o.wr == $past(insn_i.word[7])
    && (!file_wr_o.wr || (file_wr_o.addr == $past(insn_i.word[6:0]) && $stable(w_o))))
    else $error("rotate destination wrong");
  a_rot_one_cyc: assert property ((rr || rf) |=> !busy_o && !flow_o.pop)
    else $error("rotate not single cycle");
endmodule // ret_rot_monitor

bind return_rotate_exec_unit ret_rot_monitor ret_rot_monitor_i (.*);

// ---- verif/return_rotate_exec_unit_test.sv ----
// Self-checking bench for the return and rotate execute unit.
// Assumes the package, the unit and its checker are compiled first.
`timescale 1ns/1ps
module return_rotate_exec_unit_test;
  typedef struct packed {
    logic [13:0] word;
    logic [7:0]  rd, res;
    logic        c, wr, pop;
  } row_t;
  logic                  clk_i = 1'b0;
  logic                  rst_b_i = 1'b0;
  ret_rot_pkg::insn_t    insn_i = '0;
  logic [12:0]           top_of_stack_i = 13'h123;
  logic [7:0]            file_rdata_i = 8'h00;
  logic [6:0]            file_raddr_o;
  ret_rot_pkg::file_wr_t file_wr_o;
  ret_rot_pkg::flow_t    flow_o;
  logic                  busy_o, carry_o;
  logic [7:0]            w_o;
  int                    n_fail = 0;
  int                    n_tests = 0;
  // Rows run in order, so each carry-in after the first (reset carry 0) is the carry left by the row before.
  row_t rows [7] = '{'{14'h0d05, 8'he6, 8'hcc, 1'b1, 1'b0, 1'b0},
    '{14'h0c05, 8'he6, 8'hf3, 1'b0, 1'b0, 1'b0}, '{14'h0c85, 8'h01, 8'h00, 1'b1, 1'b1, 1'b0},
    '{14'h0d85, 8'h80, 8'h01, 1'b1, 1'b1, 1'b0}, '{14'h37a5, 8'h00, 8'ha5, 1'b1, 1'b0, 1'b1},
    '{14'h0008, 8'h00, 8'ha5, 1'b1, 1'b0, 1'b1}, '{14'h3f00, 8'h00, 8'ha5, 1'b1, 1'b0, 1'b0}};
  return_rotate_exec_unit return_rotate_exec_unit_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .insn_i(insn_i), .top_of_stack_i(top_of_stack_i), .file_rdata_i(file_rdata_i),
    .file_raddr_o(file_raddr_o), .file_wr_o(file_wr_o), .flow_o(flow_o), .busy_o(busy_o),
    .w_o(w_o), .carry_o(carry_o));
  initial forever #2 clk_i = ~clk_i;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #10000;
    n_fail++;
    close_out;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    #1 chk({w_o, carry_o, busy_o}, 16'h0);
    foreach (rows[i]) begin
      @(posedge clk_i);
      insn_i <= {1'b1, rows[i].word};
      file_rdata_i <= rows[i].rd;
      @(posedge clk_i);
      insn_i.valid <= 1'b0;
      #1 chk(rows[i].wr ? file_wr_o.data : w_o, rows[i].res);
      chk(carry_o, rows[i].c);
      chk(file_wr_o.wr, rows[i].wr);
      chk(flow_o.pop, rows[i].pop);
      chk(flow_o.pc_load, rows[i].pop);
      chk(busy_o, rows[i].pop);
      chk(file_raddr_o, rows[i].word[6:0]);
      if (rows[i].wr) chk(file_wr_o.addr, rows[i].word[6:0]);
      if (rows[i].pop) chk(flow_o.pc, 13'h123);
    end
    // A rotate offered during the flush cycle must be dropped.
    @(posedge clk_i);
    insn_i <= {1'b1, 14'h3412};
    @(posedge clk_i);
    insn_i <= {1'b1, 14'h0c85};
    @(posedge clk_i);
    insn_i.valid <= 1'b0;
    #1 chk(flow_o.flush, 1'b1);
    chk({file_wr_o.wr, w_o}, 9'h012);
    // A reset in mid-run clears every registered output at once.
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    file_rdata_i <= 8'he6;
    #1 chk({w_o, carry_o, busy_o}, 16'h0);
    chk(file_wr_o, 16'h0);
    chk(flow_o, 16'h0);
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    insn_i <= {1'b1, 14'h0d05};
    @(posedge clk_i);
    insn_i.valid <= 1'b0;
    #1 chk({w_o, carry_o}, 9'h199);
    close_out;
  end
endmodule // return_rotate_exec_unit_test
